// ===== dscg_top.v
// Purpose: Run, sleep and deep-sleep clock gating registers and unit gates
// Assumes: APB slave on the system control block, single clock
// Notes: Unit order in enables is adc, wdt, comparator 0, timer 2
//
// Our own choice: register access over APB.
`include "dscg_defines.vh"
module dscg_top #(
  parameter NU = 4, // Gated unit count
  parameter [NU*32-1:0] UNIT_BASES = {32'h40032000, 32'h4003C000,
                                       32'h40000000, 32'h40038000}
) (
  input wire clk, // System clock
  input wire nrst, // Async reset, active low
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB write
  input wire [31:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  input wire [3:0] pstrb, // APB byte strobes
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error
  input wire [1:0] power_state, // 0 run, 1 sleep, 2 deep-sleep
  input wire unit_sel, // Processor access request to units
  input wire [31:0] unit_addr, // Processor access address
  output wire unit_fault, // Access hits a gated-off unit
  output wire [NU-1:0] unit_clk_en, // Registered unit enables
  output wire [NU-1:0] unit_gclk, // Gated unit clocks
  output reg [1:0] adc_sample_rate, // Converter sample rate field
  output wire irq // Interrupt, level high
);

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [31:0] run_clock_config;
  reg [31:0] run_gate_ctrl_zero;
  reg [31:0] run_gate_ctrl_one;
  reg [31:0] sleep_gate_ctrl_zero;
  reg [31:0] sleep_gate_ctrl_one;
  reg [31:0] deep_sleep_gate_ctrl_zero;
  reg [31:0] deep_sleep_gate_ctrl_one;
  reg [`DSCG_I_WIDTH-1:0] int_stat;
  reg [`DSCG_I_WIDTH-1:0] int_mask;
  reg [1:0] prev_state;

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire [11:0] off = paddr[11:0];
  wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                       {8{pstrb[0]}}};

  // Keep read-only bits, merge only writable strobed bits
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] wmask;
    input [31:0] bm;
    begin
      merge = (old & ~(wmask & bm)) | (wd & wmask & bm);
    end
  endfunction

  function sel_hit;
    input [11:0] o;
    input [11:0] cand;
    begin
      sel_hit = (o == cand);
    end
  endfunction

  wire mapped = sel_hit(off, `DSCG_OFF_RUN_CFG) |
                sel_hit(off, `DSCG_OFF_RUN0) |
                sel_hit(off, `DSCG_OFF_RUN1) |
                sel_hit(off, `DSCG_OFF_SLP0) |
                sel_hit(off, `DSCG_OFF_SLP1) |
                sel_hit(off, `DSCG_OFF_DSLP0) |
                sel_hit(off, `DSCG_OFF_DSLP1) |
                sel_hit(off, `DSCG_OFF_INT_STAT) |
                sel_hit(off, `DSCG_OFF_INT_MASK) |
                sel_hit(off, `DSCG_OFF_STATE);

  // Zero-wait slave; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_clock_config <= `DSCG_CFG_RESET;
      run_gate_ctrl_zero <= `DSCG_R0_RESET;
      run_gate_ctrl_one <= `DSCG_R1_RESET;
      sleep_gate_ctrl_zero <= `DSCG_R0_RESET;
      sleep_gate_ctrl_one <= `DSCG_R1_RESET;
      deep_sleep_gate_ctrl_zero <= `DSCG_R0_RESET;
      deep_sleep_gate_ctrl_one <= `DSCG_R1_RESET;
      int_mask <= {`DSCG_I_WIDTH{1'b0}};
    end else if (wr) begin
      if (sel_hit(off, `DSCG_OFF_RUN_CFG)) begin
        run_clock_config <= merge(run_clock_config, pwdata,
                                  `DSCG_CFG_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_RUN0)) begin
        run_gate_ctrl_zero <= merge(run_gate_ctrl_zero, pwdata,
                                    `DSCG_R0_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_RUN1)) begin
        run_gate_ctrl_one <= merge(run_gate_ctrl_one, pwdata,
                                   `DSCG_R1_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_SLP0)) begin
        sleep_gate_ctrl_zero <= merge(sleep_gate_ctrl_zero, pwdata,
                                      `DSCG_R0_SLP_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_SLP1)) begin
        sleep_gate_ctrl_one <= merge(sleep_gate_ctrl_one, pwdata,
                                     `DSCG_R1_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_DSLP0)) begin
        // Only bits 16 and 3 take data; bit 6 stays at one
        deep_sleep_gate_ctrl_zero <= merge(deep_sleep_gate_ctrl_zero,
                                           pwdata, `DSCG_R0_WMASK,
                                           bmask);
      end
      if (sel_hit(off, `DSCG_OFF_DSLP1)) begin
        deep_sleep_gate_ctrl_one <= merge(deep_sleep_gate_ctrl_one, pwdata,
                                          `DSCG_R1_WMASK, bmask);
      end
      if (sel_hit(off, `DSCG_OFF_INT_MASK)) begin
        int_mask <= pwdata[`DSCG_I_WIDTH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Active set selection
  reg [31:0] act0;
  reg [31:0] act1;
  wire auto_gate = run_clock_config[`DSCG_B_AUTO];

  always @* begin
    act0 = run_gate_ctrl_zero;
    act1 = run_gate_ctrl_one;
    if (auto_gate) begin
      case (power_state)
        `DSCG_PS_SLEEP: begin
          act0 = sleep_gate_ctrl_zero;
          act1 = sleep_gate_ctrl_one;
        end
        `DSCG_PS_DEEP: begin
          act0 = deep_sleep_gate_ctrl_zero;
          act1 = deep_sleep_gate_ctrl_one;
        end
        default: begin
          act0 = run_gate_ctrl_zero;
          act1 = run_gate_ctrl_one;
        end
      endcase
    end
  end

  wire [NU-1:0] want_en;
  assign want_en = {act1[`DSCG_B_GENERAL_TIMER_TWO_GATE], act1[`DSCG_B_COMPARATOR_ZERO_GATE],
                    act0[`DSCG_B_WDT], act0[`DSCG_B_ADC]};

  genvar g;
  generate
    for (g = 0; g < NU; g = g + 1) begin : gates
      dscg_gate_cell u_gate (
        .clk(clk),
        .nrst(nrst),
        .en(want_en[g]),
        .en_q(unit_clk_en[g]),
        .gclk(unit_gclk[g])
      );
    end
  endgenerate

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_sample_rate <= `DSCG_RATE_125K;
    end else begin
      adc_sample_rate <= act0[`DSCG_B_RATE_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault detection on unit accesses
  wire unit_bad;

  dscg_fault_chk #(
    .N(NU),
    .BASES(UNIT_BASES),
    .WIN_MASK(32'hFFFFF000)
  ) u_chk (
    .addr(unit_addr),
    .unit_en(unit_clk_en),
    .hit(),
    .fault(unit_bad)
  );

  assign unit_fault = unit_sel & unit_bad;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: fault and power-state change events
  wire [`DSCG_I_WIDTH-1:0] ev;
  assign ev[`DSCG_I_FAULT] = unit_fault;
  assign ev[`DSCG_I_STATE] = (power_state != prev_state);
  wire w1c = wr & sel_hit(off, `DSCG_OFF_INT_STAT) & pstrb[0];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_stat <= {`DSCG_I_WIDTH{1'b0}};
      prev_state <= `DSCG_PS_RUN;
    end else begin
      prev_state <= power_state;
      // Set wins over a simultaneous clear
      int_stat <= (int_stat & ~(w1c ? pwdata[`DSCG_I_WIDTH-1:0] :
                   {`DSCG_I_WIDTH{1'b0}})) | ev;
    end
  end

  assign irq = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////////////
  // Read data, registered so it stands until the next access
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (off)
      `DSCG_OFF_RUN_CFG: rd_mux = run_clock_config;
      `DSCG_OFF_RUN0: rd_mux = run_gate_ctrl_zero;
      `DSCG_OFF_RUN1: rd_mux = run_gate_ctrl_one;
      `DSCG_OFF_SLP0: rd_mux = sleep_gate_ctrl_zero;
      `DSCG_OFF_SLP1: rd_mux = sleep_gate_ctrl_one;
      `DSCG_OFF_DSLP0: rd_mux = deep_sleep_gate_ctrl_zero;
      `DSCG_OFF_DSLP1: rd_mux = deep_sleep_gate_ctrl_one;
      `DSCG_OFF_INT_STAT: rd_mux = {{(32-`DSCG_I_WIDTH){1'b0}}, int_stat};
      `DSCG_OFF_INT_MASK: rd_mux = {{(32-`DSCG_I_WIDTH){1'b0}}, int_mask};
      `DSCG_OFF_STATE: rd_mux = {{(32-NU-2){1'b0}}, unit_clk_en,
                                 power_state};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Setup-phase capture so data is valid at the access edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule // dscg_top

// ===== dscg_defines.vh
// Purpose: Constants for the deep-sleep clock gating control block
// Assumes: APB slave, 32-bit data, byte addresses equal printed offsets
// Notes: Offsets are relative to the system control base
//
// Behaviour
// - Each writable gating bit is a unit clock enable; 1 clocks, 0 stops.
// - Bus access to a unit whose clock is gated off gets a bus fault.
// - After reset all gating bits are 0 except documented exceptions.
// - Run, Sleep and Deep-Sleep sets; current power state's set drives enables.
// - Sleep and Deep-Sleep sets apply only when automatic gating is selected.
// - Deep-sleep register 0 bit 16 enables converter 0 clock, resets 0.
// - Deep-sleep register 0 bit 3 enables watchdog clock, resets 0.
// - Deep-sleep register 0 resets to 0x40; only bits 16, 3 writable.
// - Deep-sleep register 0 decodes at offset 0x120 from system control base.
// - Run register 1 at 0x104 resets 0; holds comparator 0, timer 2 enables.
// - Sleep register 0 at 0x114 mirrors enables, adds two-bit sample rate.
`ifndef DSCG_DEFINES_VH
`define DSCG_DEFINES_VH

`define DSCG_SYSCTL_BASE 32'h400FE000
`define DSCG_OFF_RUN_CFG 12'h060
`define DSCG_OFF_RUN0 12'h100
`define DSCG_OFF_RUN1 12'h104
`define DSCG_OFF_SLP0 12'h114
`define DSCG_OFF_SLP1 12'h118
`define DSCG_OFF_DSLP0 12'h120
`define DSCG_OFF_DSLP1 12'h124
`define DSCG_OFF_INT_STAT 12'h130
`define DSCG_OFF_INT_MASK 12'h134
`define DSCG_OFF_STATE 12'h138

// Register 0 layout (run, sleep, deep-sleep)
`define DSCG_B_ADC 16
`define DSCG_B_WDT 3
`define DSCG_B_RATE_LO 8
`define DSCG_R0_WMASK 32'h00010008
`define DSCG_R0_SLP_WMASK 32'h00010308
`define DSCG_R0_RESET 32'h00000040
// Register 1 layout
`define DSCG_B_COMPARATOR_ZERO_GATE 24
`define DSCG_B_GENERAL_TIMER_TWO_GATE 18
`define DSCG_R1_WMASK 32'h01040000
`define DSCG_R1_RESET 32'h00000000
// Run clock configuration
`define DSCG_B_AUTO 27
`define DSCG_CFG_WMASK 32'h08000000
`define DSCG_CFG_RESET 32'h00000000
// Sample rate codes
`define DSCG_RATE_125K 2'h0
`define DSCG_RATE_250K 2'h1
// Power states
`define DSCG_PS_RUN 2'h0
`define DSCG_PS_SLEEP 2'h1
`define DSCG_PS_DEEP 2'h2
// Interrupt status bits
`define DSCG_I_FAULT 0
`define DSCG_I_STATE 1
`define DSCG_I_WIDTH 2

`endif

// ===== dscg_gate_cell.v
// Purpose: Glitch-free clock gate for one unit
// Assumes: Enable changes synchronously to clk
// Notes: Enable re-timed on the falling edge so the gated clock never slivers
module dscg_gate_cell (
  input wire clk, // Source clock
  input wire nrst, // Async reset, active low
  input wire en, // Requested enable
  output reg en_q, // Registered enable, data domain
  output wire gclk // Gated clock
);
  reg en_lat;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en;
    end
  end

  // Falling-edge capture: the enable only moves while clk is low, so the
  // gated clock never gets a shortened high phase
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      en_lat <= 1'b0;
    end else begin
      en_lat <= en_q;
    end
  end

  assign gclk = clk & en_lat;
endmodule // dscg_gate_cell

// ===== dscg_fault_chk.v
// Purpose: Flags bus accesses to units whose clock is off
// Assumes: One address window per unit, fixed size
// Notes: Combinational; the top decides how to answer
module dscg_fault_chk #(
  parameter N = 4, // Number of units
  parameter [N*32-1:0] BASES = {N{32'h00000000}}, // Unit base addresses
  parameter [31:0] WIN_MASK = 32'hFFFFF000 // Window mask
) (
  input wire [31:0] addr, // Address of the access
  input wire [N-1:0] unit_en, // Current unit enables
  output wire hit, // Address falls in some unit
  output wire fault // Address falls in a gated-off unit
);
  reg [N-1:0] match;
  integer i;

  always @* begin
    match = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      match[i] = (addr & WIN_MASK) == (BASES[i*32 +: 32] & WIN_MASK);
    end
  end

  assign hit = |match;
  assign fault = |(match & ~unit_en);
endmodule // dscg_fault_chk

// ===== dscg_top_props.sv
// Purpose: Port checks for dscg_top
// Assumes: Zero-wait APB, enables follow a state change by one edge and a register write by two
// Notes: Ports grouped per line to stay compact
`include "dscg_defines.vh"
module dscg_top_props #(
  parameter NU = 4,
  parameter [NU*32-1:0] UNIT_BASES = 0
) (
  input wire clk, // Clock
  input wire nrst, // Reset, active low
  input wire psel, penable, pwrite, pready, pslverr, // APB controls
  input wire [31:0] paddr, pwdata, prdata, // APB buses
  input wire [3:0] pstrb, // Strobes
  input wire [1:0] power_state, adc_sample_rate, // State, rate
  input wire unit_sel, unit_fault, irq, // Unit access, interrupt
  input wire [31:0] unit_addr, // Unit address
  input wire [NU-1:0] unit_clk_en, unit_gclk // Enables, clocks
);
  logic mapped;
  logic exp_fault;
  wire acc = psel && penable;
  always_comb begin
    exp_fault = 1'b0;
    for (int i = 0; i < NU; i++)
      if ((unit_addr & 32'hFFFFF000) == UNIT_BASES[i*32+:32])
        exp_fault = unit_sel && !unit_clk_en[i];
    case (paddr[11:0])
      `DSCG_OFF_RUN_CFG, `DSCG_OFF_RUN0, `DSCG_OFF_RUN1, `DSCG_OFF_SLP0,
      `DSCG_OFF_SLP1, `DSCG_OFF_DSLP0, `DSCG_OFF_DSLP1,
      `DSCG_OFF_INT_STAT, `DSCG_OFF_INT_MASK, `DSCG_OFF_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  a_decode_err: assert property (@(posedge clk) disable iff (!nrst)
    acc |-> pslverr == !mapped) else $error("decode error wrong");
  a_err_access_only: assert property (@(posedge clk) disable iff (!nrst)
    !acc |-> !pslverr) else $error("pslverr outside access");
  a_fault_gated: assert property (@(posedge clk) disable iff (!nrst)
    unit_fault == exp_fault) else $error("unit fault wrong");
  a_reset_all_off: assert property (@(posedge clk)
    !nrst |-> unit_clk_en == '0 && !irq) else $error("not off in reset");
  // Enables may only move after a register write or a state change
  a_enable_cause: assert property (@(posedge clk) disable iff (!nrst)
    $changed(unit_clk_en) |-> $past(acc && pwrite) ||
    $past(acc && pwrite, 2) || $past(power_state) != $past(power_state, 2))
    else $error("enables moved without cause");
  a_rate_nonsleep: assert property (@(posedge clk) disable iff (!nrst)
    power_state != `DSCG_PS_SLEEP && $past(power_state) != `DSCG_PS_SLEEP
    |-> adc_sample_rate == 2'h0) else $error("rate outside sleep");
  a_rdata_stands: assert property (@(posedge clk) disable iff (!nrst)
    $changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata changed outside read setup");
  a_irq_cause: assert property (@(posedge clk) disable iff (!nrst)
    $rose(irq) |-> $past(unit_fault) || $past(acc && pwrite) ||
    $past(power_state) != $past(power_state, 2) ||
    $past(power_state, 2) != $past(power_state, 3))
    else $error("irq rose without event");
endmodule // dscg_top_props
bind dscg_top dscg_top_props #(.NU(NU), .UNIT_BASES(UNIT_BASES)) u_props (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pstrb(pstrb), .power_state(power_state),
  .adc_sample_rate(adc_sample_rate), .unit_sel(unit_sel),
  .unit_fault(unit_fault), .irq(irq), .unit_addr(unit_addr),
  .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk));

// ===== tb_top.sv
// Purpose: Self-checking bench for dscg_top
// Assumes: Zero-wait APB slave, enables settle within three edges
// Notes: Enable order is adc, wdt, comparator 0, timer 2
`include "dscg_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] UB = {32'h40032000, 32'h4003C000,
                                 32'h40000000, 32'h40038000};
  logic clk = 1'b0;
  logic nrst;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] power_state = 2'h0;
  logic unit_sel = 1'b0;
  logic [31:0] unit_addr = 32'h0;
  wire pready, pslverr, unit_fault, irq;
  wire [31:0] prdata;
  wire [3:0] unit_clk_en, unit_gclk;
  wire [1:0] adc_sample_rate;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  logic [3:0] ex;
  always #5 clk = ~clk;
  dscg_top #(.NU(4), .UNIT_BASES(UB)) DUT (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .power_state(power_state), .unit_sel(unit_sel),
    .unit_addr(unit_addr), .unit_fault(unit_fault),
    .unit_clk_en(unit_clk_en), .unit_gclk(unit_gclk),
    .adc_sample_rate(adc_sample_rate), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] off,
                     input logic [31:0] wd, input logic [3:0] st);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= `DSCG_SYSCTL_BASE + {20'h0, off};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [11:0] off,
                     input logic [31:0] exp);
    apb(1'b0, off, 32'h0, 4'hF);
    chk(what, exp, rd);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc("dslp0", `DSCG_OFF_DSLP0, `DSCG_R0_RESET);
    rdc("run1", `DSCG_OFF_RUN1, `DSCG_R1_RESET);
    rdc("slp0", `DSCG_OFF_SLP0, 32'h00000040);
    rdc("cfg", `DSCG_OFF_RUN_CFG, 32'h0);
    chk("enables", 32'h0, {28'h0, unit_clk_en});
    $display("test reset values done");
    apb(1'b1, `DSCG_OFF_DSLP0, 32'hFFFFFFFF, 4'hF);
    rdc("dslp0 ones", `DSCG_OFF_DSLP0, 32'h00010048);
    // Only byte 2 strobed, so the watchdog bit must survive
    apb(1'b1, `DSCG_OFF_DSLP0, 32'h0, 4'h4);
    rdc("dslp0 strobe", `DSCG_OFF_DSLP0, 32'h00000048);
    apb(1'b1, `DSCG_OFF_DSLP0, rd | 32'h00010000, 4'hF);
    rdc("dslp0 rmw", `DSCG_OFF_DSLP0, 32'h00010048);
    apb(1'b1, `DSCG_OFF_RUN1, 32'hFFFFFFFF, 4'hF);
    rdc("run1 ones", `DSCG_OFF_RUN1, 32'h01040000);
    apb(1'b1, `DSCG_OFF_SLP0, 32'hFFFFFFFF, 4'hF);
    rdc("slp0 ones", `DSCG_OFF_SLP0, 32'h00010348);
    apb(1'b1, 12'h200, 32'hFFFFFFFF, 4'hF);
    chk("wr err", 32'h1, {31'h0, err});
    rdc("unmapped", 12'h200, 32'h0);
    $display("test access kinds done");
    // Distinct enable patterns per set make a wrong selection visible
    apb(1'b1, `DSCG_OFF_RUN0, 32'h00010000, 4'hF);
    apb(1'b1, `DSCG_OFF_RUN1, 32'h01000000, 4'hF);
    apb(1'b1, `DSCG_OFF_SLP0, 32'h00000108, 4'hF);
    apb(1'b1, `DSCG_OFF_SLP1, 32'h00040000, 4'hF);
    apb(1'b1, `DSCG_OFF_DSLP0, 32'h00010008, 4'hF);
    apb(1'b1, `DSCG_OFF_DSLP1, 32'h01040000, 4'hF);
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, `DSCG_OFF_RUN_CFG, a ? 32'h08000000 : 32'h0, 4'hF);
      for (int p = 0; p < 4; p++) begin
        power_state <= p[1:0];
        repeat (3) @(posedge clk);
        @(negedge clk);
        ex = (a == 0 || p == 0 || p == 3) ? 4'h5 : (p == 1 ? 4'hA : 4'hF);
        chk("enables", {28'h0, ex}, {28'h0, unit_clk_en});
        chk("rate", (a && p == 1), {30'h0, adc_sample_rate});
        @(posedge clk);
        #1;
        chk("gclk", {28'h0, ex}, {28'h0, unit_gclk});
        rdc("state", `DSCG_OFF_STATE, {26'h0, ex, p[1:0]});
        for (int u = 0; u < 4; u++) begin
          @(posedge clk);
          unit_sel <= 1'b1;
          unit_addr <= UB[u*32+:32] + 32'h10;
          @(negedge clk);
          chk("fault", {31'h0, !ex[u]}, {31'h0, unit_fault});
        end
        @(posedge clk);
        unit_sel <= 1'b0;
      end
    end
    $display("test gating sets done");
    rdc("status", `DSCG_OFF_INT_STAT, 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, `DSCG_OFF_INT_STAT, 32'h3, 4'hF);
    rdc("status clear", `DSCG_OFF_INT_STAT, 32'h0);
    apb(1'b1, `DSCG_OFF_INT_MASK, 32'h1, 4'hF);
    rdc("mask", `DSCG_OFF_INT_MASK, 32'h1);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge clk);
    unit_sel <= 1'b1;
    unit_addr <= UB[63:32];
    @(posedge clk);
    unit_sel <= 1'b0;
    @(negedge clk);
    chk("irq fault", 32'h1, {31'h0, irq});
    apb(1'b1, `DSCG_OFF_INT_STAT, 32'h1, 4'hF);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("enables rst", 32'h0, {28'h0, unit_clk_en});
    rdc("dslp0 rst", `DSCG_OFF_DSLP0, `DSCG_R0_RESET);
    $display("test second reset done");
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule // tb_top
